// file: hdl/pcd_clock_dividers.sv
// Prescaler and three system clock dividers with an AXI4-Lite register file
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ns

// ------------------------------------------------------------------
// One divider: emits one tick every (ratio + 1) source ticks
// ------------------------------------------------------------------
module pcd_div_counter
  import pcd_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Source and setting
  input wire logic src_tick,
  input wire pcd_div_t cfg,
  // Divided tick
  output logic tick_r
);

  logic [PCD_RATIO_W-1:0] cnt_r;
  logic [PCD_RATIO_W-1:0] cnt_nxt;
  logic tick_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    tick_nxt = 1'b0;
    if (!cfg.en) begin
      // Held static and cleared so a re-enable starts a full period [R15]
      cnt_nxt = PCD_CNT_ZERO;
    end else if (src_tick) begin
      // Compare with >= so a shrunk ratio never strands the count [R3]
      if (cnt_r >= cfg.ratio) begin
        cnt_nxt = PCD_CNT_ZERO;
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + PCD_CNT_ONE;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_r <= PCD_CNT_ZERO;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

endmodule

// Overview of operation
// R1: Prescaler divides reference clock ahead of PLL.
// R2: Prescaler enable bit 15, resets set.
// R3: Prescaler ratio divides by value plus one.
// R4: Three dividers make system clocks, both paths.
// R5: First system divider enable bit 15, resets set.
// R6: First divider codes 0,1,3 give 1,2,4.
// R7: Second system divider enable bit 15, resets set.
// R8: Second divider codes 0,1,3 give 1,2,4.
// R9: Third system divider enable bit 15, resets set.
// R10: Third divider codes 0,1,3 give 1,2,4.
// R11: Software writes only defined system ratio codes.
// R12: Bits 14:5 read zero, writes ignored.
// R13: Path select clear bypasses prescaler and PLL.
// R14: Lock frequency set by multiplier and prescaler.
// R15: Disabled divider holds output static, restarts cleanly.
module pcd_clock_dividers
  import pcd_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // AXI4-Lite write address
  input wire logic [PCD_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [PCD_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // PLL side
  input wire logic pll_out_tick,
  output logic prescaled_ref_tick,
  output logic [PCD_RATIO_W-1:0] multiplier_select,
  output logic pll_path_select,
  // System clock ticks
  output logic system_clock_one,
  output logic system_clock_two,
  output logic system_clock_three
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  pcd_div_t presc_r, presc_nxt;
  pcd_div_t sys_r [3];
  pcd_div_t sys_nxt [3];
  logic path_r, path_nxt;
  logic [PCD_RATIO_W-1:0] mult_r, mult_nxt;

  // ----------------------------------------------------------------
  // Bus channel state
  // ----------------------------------------------------------------
  logic aw_hold_r, aw_hold_nxt;
  logic w_hold_r, w_hold_nxt;
  logic [PCD_ADDR_W-1:0] waddr_r, waddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic awready_r, awready_nxt;
  logic wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  logic presc_tick;
  logic [2:0] sys_tick;
  logic sys_src;

  // ----------------------------------------------------------------
  // Read view of one divider register
  // ----------------------------------------------------------------
  function automatic logic [31:0] div_word(input pcd_div_t d);
    logic [31:0] w;
    w = '0;
    w[PCD_EN_BIT] = d.en;
    w[PCD_RATIO_W-1:0] = d.ratio;
    return w; // [R12]
  endfunction

  // ----------------------------------------------------------------
  // Write channel and register updates
  // ----------------------------------------------------------------
  always_comb begin
    logic aw_take;
    logic w_take;
    logic do_write;
    aw_take = s_axi_awvalid && awready_r;
    w_take = s_axi_wvalid && wready_r;
    do_write = 1'b0;
    aw_hold_nxt = aw_hold_r || aw_take;
    w_hold_nxt = w_hold_r || w_take;
    waddr_nxt = aw_take ? s_axi_awaddr : waddr_r;
    wdata_nxt = w_take ? s_axi_wdata : wdata_r;
    wstrb_nxt = w_take ? s_axi_wstrb : wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    presc_nxt = presc_r;
    sys_nxt = sys_r;
    path_nxt = path_r;
    mult_nxt = mult_r;
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    do_write = aw_hold_nxt && w_hold_nxt && !bvalid_r;
    if (do_write) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = PCD_RESP_OKAY;
      // Divider registers store only bit 15 and bits 4:0; their bits 14:5 are dropped [R12]
      if (waddr_nxt == PCD_ADDR_PRESC) begin
        if (wstrb_nxt[PCD_STRB_HI]) presc_nxt.en = wdata_nxt[PCD_EN_BIT]; // [R2]
        if (wstrb_nxt[PCD_STRB_LO]) presc_nxt.ratio = wdata_nxt[PCD_RATIO_W-1:0]; // [R3]
      end else if (waddr_nxt == PCD_ADDR_SYS1) begin
        if (wstrb_nxt[PCD_STRB_HI]) sys_nxt[0].en = wdata_nxt[PCD_EN_BIT]; // [R5]
        if (wstrb_nxt[PCD_STRB_LO]) sys_nxt[0].ratio = wdata_nxt[PCD_RATIO_W-1:0]; // [R6]
      end else if (waddr_nxt == PCD_ADDR_SYS2) begin
        if (wstrb_nxt[PCD_STRB_HI]) sys_nxt[1].en = wdata_nxt[PCD_EN_BIT]; // [R7]
        if (wstrb_nxt[PCD_STRB_LO]) sys_nxt[1].ratio = wdata_nxt[PCD_RATIO_W-1:0]; // [R8]
      end else if (waddr_nxt == PCD_ADDR_SYS3) begin
        if (wstrb_nxt[PCD_STRB_HI]) sys_nxt[2].en = wdata_nxt[PCD_EN_BIT]; // [R9]
        if (wstrb_nxt[PCD_STRB_LO]) sys_nxt[2].ratio = wdata_nxt[PCD_RATIO_W-1:0]; // [R10]
      end else if (waddr_nxt == PCD_ADDR_CTRL) begin
        if (wstrb_nxt[PCD_STRB_LO]) path_nxt = wdata_nxt[PCD_CTRL_PATH_BIT]; // [R13]
        if (wstrb_nxt[PCD_STRB_HI]) begin
          mult_nxt = wdata_nxt[PCD_CTRL_MULT_LSB +: PCD_RATIO_W]; // [R14]
        end
      end else if (waddr_nxt != PCD_ADDR_STAT) begin
        bresp_nxt = PCD_RESP_SLVERR;
      end
    end
    // No new address or data while a response is still pending
    awready_nxt = !aw_hold_nxt && !bvalid_nxt;
    wready_nxt = !w_hold_nxt && !bvalid_nxt;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      waddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= PCD_RESP_OKAY;
      presc_r <= PCD_PRESC_RST; // [R2] [R3]
      sys_r[0] <= PCD_SYS_RST; // [R5] [R6]
      sys_r[1] <= PCD_SYS_RST; // [R7] [R8]
      sys_r[2] <= PCD_SYS_RST; // [R9] [R10]
      path_r <= PCD_PATH_RST;
      mult_r <= PCD_MULT_RST;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      waddr_r <= waddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      presc_r <= presc_nxt;
      sys_r <= sys_nxt;
      path_r <= path_nxt;
      mult_r <= mult_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  always_comb begin
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && arready_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = PCD_RESP_OKAY;
      rdata_nxt = '0;
      if (s_axi_araddr == PCD_ADDR_PRESC) begin
        rdata_nxt = div_word(presc_r); // [R12]
      end else if (s_axi_araddr == PCD_ADDR_SYS1) begin
        rdata_nxt = div_word(sys_r[0]);
      end else if (s_axi_araddr == PCD_ADDR_SYS2) begin
        rdata_nxt = div_word(sys_r[1]);
      end else if (s_axi_araddr == PCD_ADDR_SYS3) begin
        rdata_nxt = div_word(sys_r[2]);
      end else if (s_axi_araddr == PCD_ADDR_CTRL) begin
        rdata_nxt[PCD_CTRL_PATH_BIT] = path_r;
        rdata_nxt[PCD_CTRL_MULT_LSB +: PCD_RATIO_W] = mult_r;
      end else if (s_axi_araddr == PCD_ADDR_STAT) begin
        // Live tick levels, mostly useful with slow dividers
        rdata_nxt[3:0] = {system_clock_three, system_clock_two, system_clock_one,
                          prescaled_ref_tick};
      end else begin
        rresp_nxt = PCD_RESP_SLVERR;
      end
    end
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rresp_r <= PCD_RESP_OKAY;
      rdata_r <= '0;
    end else begin
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Dividers
  // ----------------------------------------------------------------
  // Prescaler always counts reference cycles; its tick feeds the PLL [R1]
  pcd_div_counter u_presc (
    .ref_clk(ref_clk),
    .rst(rst),
    .src_tick(1'b1),
    .cfg(presc_r),
    .tick_r(presc_tick)
  );

  // Bypass takes every reference cycle, PLL mode the PLL's ticks [R13] [R4]
  assign sys_src = path_r ? pll_out_tick : 1'b1;

  // Reserved codes divide by code plus one; software must avoid them [R11]
  for (genvar i = 0; i < 3; i++) begin : g_sys
    pcd_div_counter u_sys (
      .ref_clk(ref_clk),
      .rst(rst),
      .src_tick(sys_src),
      .cfg(sys_r[i]),
      .tick_r(sys_tick[i])
    ); // [R4] [R6] [R8] [R10]
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign prescaled_ref_tick = presc_tick;
  assign multiplier_select = mult_r; // [R14]
  assign pll_path_select = path_r;
  assign system_clock_one = sys_tick[0];
  assign system_clock_two = sys_tick[1];
  assign system_clock_three = sys_tick[2];

endmodule

// file: hdl/pcd_pkg.sv
// Register map, field layout and types of the clock divider block
package pcd_pkg;

  // ----------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] PCD_IDX_PRESC = 16'h1C8A;
  localparam logic [15:0] PCD_IDX_SYS1 = 16'h1C8C;
  localparam logic [15:0] PCD_IDX_SYS2 = 16'h1C8E;
  localparam logic [15:0] PCD_IDX_SYS3 = 16'h1C90;
  localparam logic [15:0] PCD_ADDR_PRESC = PCD_IDX_PRESC << 2;
  localparam logic [15:0] PCD_ADDR_SYS1 = PCD_IDX_SYS1 << 2;
  localparam logic [15:0] PCD_ADDR_SYS2 = PCD_IDX_SYS2 << 2;
  localparam logic [15:0] PCD_ADDR_SYS3 = PCD_IDX_SYS3 << 2;
  localparam logic [15:0] PCD_ADDR_CTRL = 16'h7200;
  localparam logic [15:0] PCD_ADDR_STAT = 16'h7204;
  localparam int unsigned PCD_ADDR_W = 16;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned PCD_EN_BIT = 15;
  localparam int unsigned PCD_RATIO_W = 5;
  localparam int unsigned PCD_CTRL_PATH_BIT = 0;
  localparam int unsigned PCD_CTRL_MULT_LSB = 8;
  localparam int unsigned PCD_STRB_LO = 0;
  localparam int unsigned PCD_STRB_HI = 1;

  // ----------------------------------------------------------------
  // Types and reset values
  // ----------------------------------------------------------------
  typedef struct packed {
    logic en;
    logic [PCD_RATIO_W-1:0] ratio;
  } pcd_div_t;

  localparam pcd_div_t PCD_PRESC_RST = '{en: 1'b1, ratio: 5'h00};
  localparam pcd_div_t PCD_SYS_RST = '{en: 1'b1, ratio: 5'h03};
  localparam logic PCD_PATH_RST = 1'b0;
  localparam logic [PCD_RATIO_W-1:0] PCD_MULT_RST = 5'h00;
  localparam logic [PCD_RATIO_W-1:0] PCD_CNT_ZERO = 5'h00;
  localparam logic [PCD_RATIO_W-1:0] PCD_CNT_ONE = 5'h01;

  localparam logic [1:0] PCD_RESP_OKAY = 2'h0;
  localparam logic [1:0] PCD_RESP_SLVERR = 2'h2;

endpackage

// file: bench/pcd_clock_dividers_props.sv
// Concurrent checks on the clock divider block ports
`timescale 1ns/1ns
module pcd_props
  import pcd_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  // Clock side
  input wire logic pll_out_tick,
  input wire logic pll_path_select,
  input wire logic [PCD_RATIO_W-1:0] multiplier_select,
  input wire logic system_clock_one,
  input wire logic system_clock_two,
  input wire logic system_clock_three
);
  // --------------------
  // Properties
  // --------------------
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  property p_wr_ans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write not answered");
  property p_wr_busy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_wr_busy: assert property (p_wr_busy) else $error("write taken while busy");
  property p_rd_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_rd_busy;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_rd_busy: assert property (p_rd_busy) else $error("read taken while busy");
  property p_rsv_zero;
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0 && s_axi_rdata[14:13] == 2'h0
      && s_axi_rdata[7:5] == 3'h0;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits not zero");
  property p_rst_vals;
    $fell(rst) |-> !pll_path_select && multiplier_select == PCD_MULT_RST;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("bad control after reset");
  property p_cfg_hold;
    !$rose(s_axi_bvalid) |-> $stable(multiplier_select) && $stable(pll_path_select);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("control moved without write");
  // Allows one stage of input registering ahead of the divider
  property p_pll_src;
    $past(pll_path_select) && (system_clock_one || system_clock_two || system_clock_three)
      |-> $past(pll_out_tick) || $past(pll_out_tick, 2);
  endproperty
  a_pll_src: assert property (p_pll_src) else $error("tick without pll source");
endmodule

bind pcd_clock_dividers pcd_props u_props (.*);

// file: bench/pcd_clock_dividers_tb.sv
// Self-checking bench for the clock divider block
`timescale 1ns/1ns
module pcd_clock_dividers_tb;
  import pcd_pkg::*;
  // --------------------
  // Signals
  // --------------------
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  logic [PCD_ADDR_W-1:0] s_axi_awaddr = '0;
  logic [PCD_ADDR_W-1:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  logic pll_out_tick = 1'h0;
  logic pll_run = 1'h0;
  logic [1:0] phase = 2'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic prescaled_ref_tick, pll_path_select;
  logic system_clock_one, system_clock_two, system_clock_three;
  logic [PCD_RATIO_W-1:0] multiplier_select;
  logic [15:0] div_a [4] = '{PCD_ADDR_PRESC, PCD_ADDR_SYS1, PCD_ADDR_SYS2, PCD_ADDR_SYS3};
  int err_total = 0;
  int checks = 0;
  int cnt [4];

  pcd_clock_dividers uut (.*);

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  // PLL stand-in: one strobe every third cycle
  always @(posedge ref_clk) begin
    phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
    pll_out_tick <= pll_run && phase == 2'h2;
  end

  // --------------------
  // Helpers
  // --------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_awvalid || s_axi_wvalid);
    while (!s_axi_bvalid) @(posedge ref_clk);
    s_axi_bready <= 1'h0;
    chk("bresp", 32'(er), 32'(s_axi_bresp));
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge ref_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge ref_clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    chk("rdata", ed, s_axi_rdata);
    chk("rresp", 32'(er), 32'(s_axi_rresp));
  endtask

  // Settle first: a ratio change may leave one odd period behind
  task automatic count(input int n);
    cnt = '{default: 0};
    repeat (40) @(posedge ref_clk);
    repeat (n) begin
      @(posedge ref_clk);
      cnt[0] += int'(prescaled_ref_tick === 1'h1);
      cnt[1] += int'(system_clock_one === 1'h1);
      cnt[2] += int'(system_clock_two === 1'h1);
      cnt[3] += int'(system_clock_three === 1'h1);
    end
  endtask

  // --------------------
  // Scenarios
  // --------------------
  task automatic t_fields;
    for (int i = 0; i < 4; i++) begin
      rd(div_a[i], (i == 0) ? 32'h8000 : 32'h8003, PCD_RESP_OKAY);
      wr(div_a[i], (i == 0) ? 32'hFFFF_FFFF : 32'hFFFF_FFE3, PCD_RESP_OKAY);
      rd(div_a[i], (i == 0) ? 32'h801F : 32'h8003, PCD_RESP_OKAY);
    end
    // Byte strobes: the high byte holds the enable, the low byte the ratio
    s_axi_wstrb <= 4'h2;
    wr(div_a[1], 32'h0, PCD_RESP_OKAY);
    rd(div_a[1], 32'h0003, PCD_RESP_OKAY);
    s_axi_wstrb <= 4'h1;
    wr(div_a[1], 32'h8000, PCD_RESP_OKAY);
    rd(div_a[1], 32'h0, PCD_RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(PCD_ADDR_CTRL, 32'h0, PCD_RESP_OKAY);
    wr(16'h7300, 32'h1, PCD_RESP_SLVERR);
    rd(16'h7300, 32'h0, PCD_RESP_SLVERR);
    $display("test fields done");
  endtask

  task automatic t_ratio;
    logic [31:0] pc [3] = '{32'h0, 32'h4, 32'h1F};
    logic [31:0] sc [3] = '{32'h0, 32'h1, 32'h3};
    for (int k = 0; k < 3; k++) begin
      wr(div_a[0], 32'h8000 | pc[k], PCD_RESP_OKAY);
      for (int i = 1; i < 4; i++) wr(div_a[i], 32'h8000 | sc[k], PCD_RESP_OKAY);
      count(160);
      chk("presc ticks", 160 / (pc[k] + 1), cnt[0]);
      for (int i = 1; i < 4; i++) chk("sys ticks", 160 / (sc[k] + 1), cnt[i]);
      // Divide by one in bypass keeps every tick level high
      if (k == 0) rd(PCD_ADDR_STAT, 32'hF, PCD_RESP_OKAY);
    end
    $display("test ratio done");
  endtask

  task automatic t_disable;
    for (int i = 0; i < 4; i++) wr(div_a[i], 32'h1, PCD_RESP_OKAY);
    count(64);
    for (int i = 0; i < 4; i++) chk("off ticks", 32'h0, cnt[i]);
    wr(PCD_ADDR_STAT, 32'hF, PCD_RESP_OKAY);
    rd(PCD_ADDR_STAT, 32'h0, PCD_RESP_OKAY);
    for (int i = 0; i < 4; i++) wr(div_a[i], 32'h8001, PCD_RESP_OKAY);
    count(64);
    for (int i = 0; i < 4; i++) chk("on ticks", 32'h20, cnt[i]);
    $display("test disable done");
  endtask

  task automatic t_pll;
    wr(PCD_ADDR_CTRL, 32'h0501, PCD_RESP_OKAY);
    rd(PCD_ADDR_CTRL, 32'h0501, PCD_RESP_OKAY);
    chk("mult", 32'h5, 32'(multiplier_select));
    chk("path", 32'h1, 32'(pll_path_select));
    pll_run <= 1'h1;
    count(48);
    chk("presc ticks", 32'h18, cnt[0]);
    for (int i = 1; i < 4; i++) chk("pll ticks", 32'h8, cnt[i]);
    $display("test pll done");
  endtask

  // Reset in mid-run, with the PLL path and a multiplier set beforehand
  task automatic t_reset;
    @(posedge ref_clk);
    rst <= 1'h1;
    pll_run <= 1'h0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'h0;
    @(posedge ref_clk);
    chk("path rst", 32'h0, 32'(pll_path_select));
    chk("mult rst", 32'h0, 32'(multiplier_select));
    rd(div_a[0], 32'h8000, PCD_RESP_OKAY);
    rd(div_a[1], 32'h8003, PCD_RESP_OKAY);
    rd(div_a[2], 32'h8003, PCD_RESP_OKAY);
    rd(div_a[3], 32'h8003, PCD_RESP_OKAY);
    $display("test reset done");
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'h0;
    t_fields();
    t_ratio();
    t_disable();
    t_pll();
    t_reset();
    test_done();
  end

  // Whole run needs about 1050 cycles; allow several times that
  initial begin
    #100000;
    err_total++;
    test_done();
  end
endmodule
